// ### usr8_regs.vh
// Offsets, field positions, mode codes and reset values of the shift register block
`ifndef USR8_REGS_VH
`define USR8_REGS_VH

// Register byte offsets
`define OFS_CTRL         8'h00
`define OFS_STATUS       8'h04
`define OFS_LOG          8'h08

// Control register fields
`define CTRL_LOG_EN      0
`define CTRL_RESET       32'h00000000

// Status register fields
`define ST_STATE_LSB     0
`define ST_STATE_MSB     7
`define ST_DRIVE         8
`define ST_MODE_LSB      9
`define ST_MODE_MSB      10
`define ST_OVERFLOW      11
`define ST_EMPTY         12
`define ST_FULL          13

// Log register fields
`define LOG_VALID        8

// Mode codes, {mode_sel_hi, mode_sel_lo}
`define MODE_HOLD        2'h0
`define MODE_RIGHT       2'h1
`define MODE_LEFT        2'h2
`define MODE_LOAD        2'h3

// Reset value and log FIFO size
`define STATE_RESET      8'h00
`define LOG_DEPTH        16
`define LOG_AW           4

`endif

// ### log_mem.v
// Simple dual-port memory with registered read data and write-through
`timescale 1ns/1ns
module log_mem #(
  parameter WIDTH = 8,
  parameter AW    = 4
) (
  // Clock
  input  wire             pclk,
  // Write port
  input  wire             we,
  input  wire [AW-1:0]    waddr,
  input  wire [WIDTH-1:0] wdata,
  // Read port
  input  wire [AW-1:0]    raddr,
  output reg  [WIDTH-1:0] rdata
);

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // Write, then registered read with bypass of a same-address write
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // log_mem

// ### word_fifo.v
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
module word_fifo #(
  parameter WIDTH = 8,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output reg              out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  // Fill state
  output wire             full,
  output wire             empty
);

  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

  reg  [AW-1:0] wr_ptr_r;
  reg  [AW-1:0] rd_ptr_r;
  reg  [AW:0]   count_r;
  reg  [AW-1:0] rd_ptr_nxt;
  reg  [AW:0]   count_nxt;
  wire          push;
  wire          pop;

  assign full     = (count_r == DEPTH);
  assign empty    = (count_r == {(AW+1){1'b0}});
  assign in_ready = ~full;
  assign push     = in_valid & ~full;
  assign pop      = out_valid & out_ready;

  // Next pointer and count
  always @* begin
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    count_nxt  = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Pointers, count and output valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r  <= {AW{1'b0}};
      rd_ptr_r  <= {AW{1'b0}};
      count_r   <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      rd_ptr_r  <= rd_ptr_nxt;
      count_r   <= count_nxt;
      out_valid <= (count_nxt != {(AW+1){1'b0}});
    end
  end

  // Storage, read data follows the next read pointer
  log_mem #(
    .WIDTH (WIDTH),
    .AW    (AW)
  ) u_mem (
    .pclk  (pclk),
    .we    (push),
    .waddr (wr_ptr_r),
    .wdata (in_data),
    .raddr (rd_ptr_nxt),
    .rdata (out_data)
  );

endmodule // word_fifo

// ### universal_shift_register_8bit.v
// Eight-bit universal shift and storage register with shared bus pins and APB status
//
// Contract
// - Eight-bit state changes only on clock rise
// - Low master clear zeroes state, overrides all
// - Selects decode load, right, left, hold
// - Shift right: serial in to bit 0
// - Shift left: serial in to bit 7
// - Load captures bus pin n into bit n
// - State bits drive bus through three-state drivers
// - Either enable high floats all bus pins
// - Operations continue while drivers are disabled
// - Both selects high also disable bus drivers
// - Bits 0 and 7 always on taps
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "usr8_regs.vh"
module universal_shift_register_8bit #(
  parameter WIDTH    = 8,
  parameter LOG_AW   = `LOG_AW
) (
  // APB clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // APB slave
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  // Shift register pins
  input  wire             shift_clock,
  input  wire             master_clear_n,
  input  wire             mode_sel_lo,
  input  wire             mode_sel_hi,
  input  wire             right_serial_in,
  input  wire             left_serial_in,
  input  wire             drive_en_a_n,
  input  wire             drive_en_b_n,
  // Shared bus pins
  input  wire [WIDTH-1:0] par_bus_i,
  output reg  [WIDTH-1:0] par_bus_o,
  output reg  [WIDTH-1:0] par_bus_oe,
  // Cascade taps
  output reg              bit_zero_tap,
  output reg              bit_seven_tap
);

  // Bus pins plus seven control pins pass the synchroniser
  localparam NSYNC = WIDTH + 7;

  // Synchroniser stages for all pin inputs except master clear
  reg  [NSYNC-1:0] sync1_r;
  reg  [NSYNC-1:0] sync2_r;
  reg              clk_seen_r;
  wire             clk_s;
  wire             sel_lo_s;
  wire             sel_hi_s;
  wire             ser_r_s;
  wire             ser_l_s;
  wire             en_a_n_s;
  wire             en_b_n_s;
  wire [WIDTH-1:0] bus_s;
  wire [1:0]       mode;
  wire             clk_rise;
  wire             clear_n;
  reg              clr_sync1_r;
  reg              clr_sync2_r;

  // Register state
  reg  [WIDTH-1:0] state_r;
  reg  [WIDTH-1:0] state_nxt;
  reg              drive_r;
  reg  [31:0]      ctrl_r;
  reg              overflow_r;
  reg  [WIDTH-1:0] pend_r;
  reg              pend_valid_r;

  // FIFO wires
  wire             fifo_in_ready;
  wire             fifo_out_valid;
  wire [WIDTH-1:0] fifo_out_data;
  wire             fifo_full;
  wire             fifo_empty;
  wire             fifo_pop;

  // APB decode
  wire             apb_access;
  wire             apb_done;
  wire             hit_ctrl;
  wire             hit_status;
  wire             hit_log;
  wire             log_event;
  wire             pend_push;

  // Two flip-flops on every pin input except master clear
  // Every level that the shift logic reads comes from the second stage, so
  // selects, serial data and bus levels share the shift clock's latency
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= {NSYNC{1'b0}};
      sync2_r <= {NSYNC{1'b0}};
    end else begin
      sync1_r <= {par_bus_i, drive_en_b_n, drive_en_a_n, left_serial_in,
                  right_serial_in, mode_sel_hi, mode_sel_lo, shift_clock};
      sync2_r <= sync1_r;
    end
  end

  // Second-stage taps of the synchroniser
  assign clk_s    = sync2_r[0];
  assign sel_lo_s = sync2_r[1];
  assign sel_hi_s = sync2_r[2];
  assign ser_r_s  = sync2_r[3];
  assign ser_l_s  = sync2_r[4];
  assign en_a_n_s = sync2_r[5];
  assign en_b_n_s = sync2_r[6];
  assign bus_s    = sync2_r[NSYNC-1:7];
  assign mode     = {sel_hi_s, sel_lo_s};

  // Rising edge of the synchronised shift clock
  // Idle low after reset, so a low pin gives no false edge at release
  // Pulses shorter than one pclk on either level may be missed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_seen_r <= 1'b0;
    end else begin
      clk_seen_r <= clk_s;
    end
  end

  assign clk_rise = clk_s & ~clk_seen_r;

  // Master clear acts at once, together with system reset
  // Used only as an asynchronous reset, never read by clocked logic
  assign clear_n = presetn & master_clear_n;

  // Clear release on pclk: drops at once, rises two cycles after release
  // The log logic reads this instead of the raw pin, so no metastable level
  // reaches it
  always @(posedge pclk or negedge clear_n) begin
    if (!clear_n) begin
      clr_sync1_r <= 1'b0;
      clr_sync2_r <= 1'b0;
    end else begin
      clr_sync1_r <= 1'b1;
      clr_sync2_r <= clr_sync1_r;
    end
  end

  // Mode decode and next state
  // Codes are {mode_sel_hi, mode_sel_lo}; hold keeps the state unchanged
  always @* begin
    state_nxt = state_r;
    case (mode)
      `MODE_HOLD: begin
        state_nxt = state_r;
      end
      `MODE_RIGHT: begin
        state_nxt = {state_r[WIDTH-2:0], ser_r_s};
      end
      `MODE_LEFT: begin
        state_nxt = {ser_l_s, state_r[WIDTH-1:1]};
      end
      `MODE_LOAD: begin
        state_nxt = bus_s;
      end
      default: begin
        state_nxt = state_r;
      end
    endcase
  end

  // State flip-flops, asynchronous clear overrides clock and selects
  // The enables play no part here, so work goes on with the bus floating
  // A clear in mid-shift wins; the state stays zero until it is lifted
  always @(posedge pclk or negedge clear_n) begin
    if (!clear_n) begin
      state_r <= `STATE_RESET;
    end else if (clk_rise) begin
      state_r <= state_nxt;
    end
  end

  // Driver enable: both enables low and not in load mode
  // Registered so the pins change cleanly; drivers let go three pclk
  // after load is selected, before the far side starts to drive
  // Either enable high floats all eight pins together
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= ~en_a_n_s & ~en_b_n_s
                 & (mode != `MODE_LOAD);
    end
  end

  // Bus drivers and cascade taps
  // Taps follow the state whatever the enables, for cascading stages
  always @* begin
    par_bus_o     = state_r;
    par_bus_oe    = {WIDTH{drive_r}};
    bit_zero_tap  = state_r[0];
    bit_seven_tap = state_r[WIDTH-1];
  end

  // Snapshot of each clocked change, held until the FIFO takes it
  // A second event while the snapshot still waits is dropped and flagged
  // No event while master clear holds the state at zero
  assign log_event = ctrl_r[`CTRL_LOG_EN] & clk_rise & clr_sync2_r & (mode != `MODE_HOLD);
  assign pend_push = pend_valid_r & fifo_in_ready;

  // Holding register, emptied when the FIFO takes its word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r       <= {WIDTH{1'b0}};
      pend_valid_r <= 1'b0;
    end else begin
      if (log_event && (!pend_valid_r || pend_push)) begin
        pend_r       <= state_nxt;
        pend_valid_r <= 1'b1;
      end else if (pend_push) begin
        pend_valid_r <= 1'b0;
      end
    end
  end

  // Log FIFO between the shift logic and software
  // Depth set by LOG_AW; a full FIFO holds back the snapshot register
  // Reads of the log register pop one word each
  word_fifo #(
    .WIDTH (WIDTH),
    .AW    (LOG_AW)
  ) u_log (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (pend_valid_r),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_r),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  // APB access decode, answer one cycle into the access phase
  // pready is a one-cycle pulse, so each access phase lasts two cycles
  // and a held request cannot be taken twice
  assign apb_access = psel & penable;
  assign apb_done   = apb_access & ~pready;
  assign hit_ctrl   = (paddr == `OFS_CTRL);
  assign hit_status = (paddr == `OFS_STATUS);
  assign hit_log    = (paddr == `OFS_LOG);
  assign fifo_pop   = apb_done & ~pwrite & hit_log;

  // Control register and overflow flag, a new overflow wins over its clear
  // Only the log enable bit is kept; the rest of the word reads as zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= `CTRL_RESET;
      overflow_r <= 1'b0;
    end else begin
      if (apb_done && pwrite && hit_ctrl) begin
        ctrl_r <= {{31{1'b0}}, pwdata[`CTRL_LOG_EN]};
      end
      if (log_event && pend_valid_r && !pend_push) begin
        overflow_r <= 1'b1;
      end else if (apb_done && pwrite && hit_status && pwdata[`ST_OVERFLOW]) begin
        overflow_r <= 1'b0;
      end
    end
  end

  // APB answer registers
  // Read data stands only in the cycle of pready and is zero otherwise
  // Unmapped addresses answer with pslverr and zero data, no side effect
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_done;
      pslverr <= apb_done & ~(hit_ctrl | hit_status | hit_log);
      prdata  <= 32'h00000000;
      if (apb_done && !pwrite) begin
        if (hit_ctrl) begin
          prdata <= ctrl_r;
        end else if (hit_status) begin
          prdata[`ST_STATE_MSB:`ST_STATE_LSB] <= state_r;
          prdata[`ST_DRIVE]                   <= drive_r;
          prdata[`ST_MODE_MSB:`ST_MODE_LSB]   <= mode;
          prdata[`ST_OVERFLOW]                <= overflow_r;
          prdata[`ST_EMPTY]                   <= fifo_empty;
          prdata[`ST_FULL]                    <= fifo_full;
        end else if (hit_log) begin
          prdata[WIDTH-1:0]   <= fifo_out_valid ? fifo_out_data : {WIDTH{1'b0}};
          prdata[`LOG_VALID]  <= fifo_out_valid;
        end
      end
    end
  end

endmodule // universal_shift_register_8bit

// ### usr8_monitor.sv
// Checker of the shift register pin behaviour
`timescale 1ns/1ns
module usr8_monitor (
  // Clock and reset
  input wire       pclk,
  input wire       presetn,
  // Control pins
  input wire       shift_clock,
  input wire       master_clear_n,
  input wire       mode_sel_lo,
  input wire       mode_sel_hi,
  input wire       right_serial_in,
  input wire       left_serial_in,
  input wire       drive_en_a_n,
  input wire       drive_en_b_n,
  // Bus
  input wire [7:0] par_bus_i,
  input wire [7:0] par_bus_o,
  input wire [7:0] par_bus_oe
);
  reg [3:0] since_r;
  reg [7:0] prev_r;
  // Age of the last shift clock rise, previous state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_r <= 4'hF;
      prev_r  <= 8'h00;
    end else begin
      prev_r <= par_bus_o;
      if ($rose(shift_clock)) since_r <= 4'h0;
      else if (since_r != 4'hF) since_r <= since_r + 4'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mode steady with clear inactive
  sequence held(l, h);
    (mode_sel_lo == l && mode_sel_hi == h && master_clear_n)[*6];
  endsequence
  sequence moved;
    $changed(par_bus_o);
  endsequence
  sequence drivers_on;
    (!drive_en_a_n && !drive_en_b_n && !(mode_sel_lo && mode_sel_hi))[*6];
  endsequence
  AST_CLEAR: assert property (!master_clear_n |-> par_bus_o == 8'h00)
    else $error("state not cleared");
  AST_EDGE: assert property (moved ##0 master_clear_n ##0 $past(master_clear_n) |-> since_r >= 4'h1 && since_r <= 4'h6)
    else $error("state moved without clock");
  AST_RIGHT: assert property (held(1'b1, 1'b0) ##0 moved |-> par_bus_o == {prev_r[6:0], right_serial_in})
    else $error("bad right shift");
  AST_LEFT: assert property (held(1'b0, 1'b1) ##0 moved |-> par_bus_o == {left_serial_in, prev_r[7:1]})
    else $error("bad left shift");
  AST_LOAD: assert property (held(1'b1, 1'b1) ##0 moved |-> par_bus_o == par_bus_i)
    else $error("bad load");
  AST_OFF: assert property ((drive_en_a_n || drive_en_b_n)[*6] |-> par_bus_oe == 8'h00)
    else $error("bus driven while disabled");
  AST_LOADOFF: assert property ((mode_sel_lo && mode_sel_hi)[*6] |-> par_bus_oe == 8'h00)
    else $error("bus driven in load");
  AST_DRIVE: assert property (drivers_on |-> par_bus_oe == 8'hFF)
    else $error("bus not driven");
  AST_HOLD: assert property (held(1'b0, 1'b0) |-> $stable(par_bus_o))
    else $error("state moved in hold");
endmodule // usr8_monitor

// ### usr8_bus_peer.sv
// Far-side bus logic that drives load values onto the shared pins
`timescale 1ns/1ns
module usr8_bus_peer (
  // Clock
  input wire        pclk,
  // Load request
  input wire        drive,
  input wire [7:0]  value,
  // Design drivers
  input wire [7:0]  par_bus_o,
  input wire [7:0]  par_bus_oe,
  // Resolved pins
  output wire [7:0] wire_lvl
);
  reg  [7:0] float_r = 8'h5A;
  // Drive only once the design has let go
  wire       peer_on = drive && par_bus_oe == 8'h00;
  // Undriven pins show a pattern flipping every cycle
  assign wire_lvl = (par_bus_oe & par_bus_o) | (~par_bus_oe & (peer_on ? value : float_r));
  // Flip the floating pattern
  always @(posedge pclk) float_r <= ~float_r;
endmodule // usr8_bus_peer

// ### test_universal_shift_register_8bit.sv
// Bench for the eight-bit universal shift register
`timescale 1ns/1ns
module test_universal_shift_register_8bit;
  reg         pclk, presetn, psel, penable, pwrite, err, log_on;
  reg         sclk, clr_n, lo, hi, rsi, lsi, ena_n, enb_n, drive;
  reg  [7:0]  paddr, pdrv, st;
  reg  [31:0] pwdata, rd, seed;
  reg  [7:0]  logq [0:31];
  wire [31:0] prdata;
  wire        pready, pslverr, tap0, tap7;
  wire [7:0]  bus_o, bus_oe, bus;
  integer     num_errors, checks, nlog, i;

  universal_shift_register_8bit uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_clock(sclk), .master_clear_n(clr_n), .mode_sel_lo(lo), .mode_sel_hi(hi),
    .right_serial_in(rsi), .left_serial_in(lsi), .drive_en_a_n(ena_n), .drive_en_b_n(enb_n),
    .par_bus_i(bus), .par_bus_o(bus_o), .par_bus_oe(bus_oe), .bit_zero_tap(tap0), .bit_seven_tap(tap7)
  );
  usr8_bus_peer peer (.pclk(pclk), .drive(drive), .value(pdrv), .par_bus_o(bus_o), .par_bus_oe(bus_oe), .wire_lvl(bus));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // Expected state after one clock in mode m
  function [7:0] nxt(input [7:0] s, input [1:0] m, input [7:0] d);
    case (m)
      2'h1: nxt = {s[6:0], d[0]};
      2'h2: nxt = {d[7], s[7:1]};
      2'h3: nxt = d;
      default: nxt = s;
    endcase
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // APB transfer; data and error taken at the ready edge
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // One shift clock pulse in mode m, data d, enables e
  task op(input [1:0] m, input [7:0] d, input [1:0] e);
    begin
      {hi, lo} <= m;
      {enb_n, ena_n} <= e;
      {lsi, rsi} <= {d[7], d[0]};
      pdrv <= d;
      drive <= (m == 2'h3);
      repeat (6) @(posedge pclk);
      sclk <= 1'b1;
      repeat (4) @(posedge pclk);
      sclk <= 1'b0;
      repeat (6) @(posedge pclk);
      st = clr_n ? nxt(st, m, d) : 8'h00;
      if (log_on && m != 2'h0) begin
        logq[nlog] = st;
        nlog = nlog + 1;
      end
      chk({22'h0, tap7, tap0, bus_o}, {22'h0, st[7], st[0], st});
      chk({24'h0, bus_oe}, (e != 2'h0 || m == 2'h3) ? 32'h00 : 32'hFF);
    end
  endtask
  task report_and_stop;
    begin
      $display("errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors = num_errors + 1;
    report_and_stop;
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, sclk, lo, hi, rsi, lsi, drive, log_on} = 11'h000;
    {clr_n, ena_n, enb_n} = 3'h7;
    {paddr, pdrv, st} = 24'h000000;
    pwdata = 32'h0;
    seed = 32'h2E;
    {num_errors, checks, nlog} = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Corner cases: each mode, clear over a load, load with drivers off
    op(2'h3, 8'hA5, 2'h0);
    op(2'h1, 8'h01, 2'h1);
    op(2'h2, 8'h80, 2'h2);
    op(2'h0, 8'hFF, 2'h0);
    clr_n <= 1'b0;
    op(2'h3, 8'hFF, 2'h0);
    clr_n <= 1'b1;
    op(2'h3, 8'h3C, 2'h3);
    // Log on, random traffic overruns it
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, err}, 32'h0);
    log_on = 1'b1;
    for (i = 0; i < 20; i = i + 1) begin
      seed = xs(seed);
      op((seed[1:0] == 2'h0) ? 2'h3 : seed[1:0], seed[15:8], seed[17:16]);
    end
    apb(1'b0, 8'h04, 32'h0);
    chk({21'h0, rd[13:11], rd[7:0]}, {21'h0, 3'h5, st});
    // Drain until empty
    for (i = 0; i < 18; i = i + 1) begin
      apb(1'b0, 8'h08, 32'h0);
      chk({23'h0, rd[8:0]}, (i < 17) ? {23'h1, logq[i]} : 32'h0);
    end
    // Writing one to the overflow bit clears it; log now empty
    apb(1'b1, 8'h04, 32'h00000800);
    apb(1'b0, 8'h04, 32'h0);
    chk({21'h0, rd[13:11], rd[7:0]}, {21'h0, 3'h2, st});
    report_and_stop;
  end
endmodule // test_universal_shift_register_8bit

bind universal_shift_register_8bit usr8_monitor mon (
  .pclk(pclk), .presetn(presetn), .shift_clock(shift_clock), .master_clear_n(master_clear_n),
  .mode_sel_lo(mode_sel_lo), .mode_sel_hi(mode_sel_hi), .right_serial_in(right_serial_in),
  .left_serial_in(left_serial_in), .drive_en_a_n(drive_en_a_n), .drive_en_b_n(drive_en_b_n),
  .par_bus_i(par_bus_i), .par_bus_o(par_bus_o), .par_bus_oe(par_bus_oe)
);
